//--- pkg/src_pkg.sv
package src_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int DRAM_OFF_MIN_US = 1000;
	localparam int DRAM_OFF_MIN_CYCLES = DRAM_OFF_MIN_US * CLK_MHZ;
	localparam int ACK_ZERO_NS = 160;
	localparam int ACK_ZERO_CYCLES = (ACK_ZERO_NS * CLK_MHZ + 999) / 1000;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_POLICY = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [31:0] POLICY_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int POL_SX_EN_BIT = 27;
	localparam int POL_AG3_EN_BIT = 28;
	localparam int POL_DSX_DIS_BIT = 29;
	localparam int POL_DC_DIS_BIT = 30;
	localparam int CTL_STRETCH_BIT = 3;
	localparam int CTL_WLAN_KEEP_BIT = 4;
	localparam int CTL_MODE_LSB = 5;
	localparam int CTL_DIR_BIT = 7;
	localparam int CTL_DATA_BIT = 8;
	localparam int STS_STATE_LSB = 0;
	localparam int STS_BATTERY_LOW_N_BIT = 3;
	localparam int STS_DRAM_SHORT_BIT = 4;
	localparam int STS_MGMT_RAN_BIT = 5;
	localparam int STS_PIN_BIT = 6;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PWR_WORK,
		PWR_RAM,
		PWR_DISK,
		PWR_SOFT,
		PWR_DEEP
	} src_pwr_type;
	typedef enum logic [1:0] {
		PIN_ACK,
		PIN_WARN,
		PIN_GPIO
	} src_pin_mode_type;
	typedef enum logic [1:0] {
		RST_NONE,
		RST_POWER_CYCLE,
		RST_GLOBAL,
		RST_STRAIGHT
	} src_rst_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} src_bus_req_type;
	typedef struct packed {
		logic mgmt_on_req;
		logic mgmt_phy_keep;
		logic mgmt_wlan_access;
		logic mgmt_wlan_keep;
		logic mgmt_ack_level;
	} src_mgmt_type;
endpackage : src_pkg

//--- rtl/src_sleep_rail_control.sv
// The register addresses and the address-and-strobe port were decided locally.
module src_sleep_rail_control
	import src_pkg::*;
#(
	parameter int DRAM_MIN_CYCLES = DRAM_OFF_MIN_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire src_bus_req_type bus_req,
	output logic [31:0] rd_data,
	input wire src_pwr_type sleep_target,
	input wire src_mgmt_type mgmt,
	input wire src_rst_type reset_kind,
	input wire logic on_battery,
	input wire logic core_power_good,
	input wire logic battery_low_n,
	input wire logic suspend_well_reset_n,
	input wire logic rtc_well_reset_n,
	input wire logic secondary_rtc_reset_n,
	input wire logic shared_gp_pin_in,
	output logic sleep_ram_rail_off_n,
	output logic sleep_disk_rail_off_n,
	output logic soft_off_rail_off_n,
	output logic mgmt_rail_off_n,
	output logic wired_phy_rail_off_n,
	output logic wireless_phy_rail_off_n,
	output logic platform_reset_n,
	output logic battery_smi,
	output logic shared_gp_pin_out,
	output logic shared_gp_pin_oe
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	src_pwr_type state_reg, state_next;
	logic [31:0] policy_reg;
	logic [31:0] ctrl_reg;
	logic mgmt_ran_reg;
	logic dram_short_reg;
	logic [23:0] dram_cnt_reg;
	logic [7:0] ack_cnt_reg;
	logic bat_meta_reg, bat_sync_reg, bat_prev_reg;
	logic batt_low;
	logic dram_met;
	logic wake_ok;
	logic ram_on, mgmt_on, wired_on, wireless_on;
	logic pin_out_next, pin_oe_next;
	logic [31:0] status_word;
	src_pin_mode_type pin_mode;

	assign batt_low = bat_sync_reg;
	assign dram_met = dram_cnt_reg >= 24'(DRAM_MIN_CYCLES);
	assign pin_mode = src_pin_mode_type'(ctrl_reg[CTL_MODE_LSB +: 2]);

	// ----------------------------------------
	// Battery-low synchroniser
	// ----------------------------------------
	// two-stage sync
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bat_meta_reg <= 1'b0;
			bat_sync_reg <= 1'b0;
			bat_prev_reg <= 1'b0;
		end else if (clk_en) begin
			bat_meta_reg <= !battery_low_n;
			bat_sync_reg <= bat_meta_reg;
			bat_prev_reg <= bat_sync_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			battery_smi <= 1'b0;
		end else if (clk_en) begin
			battery_smi <= bat_sync_reg && !bat_prev_reg && state_reg == PWR_WORK;
		end
	end

	// ----------------------------------------
	// Sleep state sequencing
	// ----------------------------------------
	// Wake is refused while power is short or DRAM has not been off long enough
	always_comb begin
		wake_ok = 1'b1;
		if (batt_low) begin
			wake_ok = 1'b0;
		end
		if (ctrl_reg[CTL_STRETCH_BIT] && state_reg >= PWR_DISK && !dram_met) begin
			wake_ok = 1'b0;
		end
		state_next = state_reg;
		if (sleep_target >= state_reg || wake_ok) begin
			state_next = sleep_target;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= PWR_SOFT;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// DRAM off-time counter, saturates so it never wraps to a false short
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dram_cnt_reg <= 24'h00_0000;
		end else if (clk_en) begin
			if (sleep_disk_rail_off_n) begin
				dram_cnt_reg <= 24'h00_0000;
			end else if (!dram_met) begin
				dram_cnt_reg <= dram_cnt_reg + 24'h00_0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dram_short_reg <= 1'b0;
		end else if (clk_en) begin
			if (!sleep_disk_rail_off_n && state_reg < PWR_DISK && !dram_met) begin
				dram_short_reg <= 1'b1;
			end else if (bus_req.wr && bus_req.addr == REG_STATUS && bus_req.wdata[STS_DRAM_SHORT_BIT]) begin
				dram_short_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Rail decisions
	// ----------------------------------------
	always_comb begin
		ram_on = state_reg == PWR_WORK;
		mgmt_on = ram_on || (mgmt.mgmt_on_req && state_reg != PWR_DEEP);
		wired_on = ram_on || mgmt_on;
		if (mgmt.mgmt_phy_keep && mgmt_ran_reg) begin
			wired_on = 1'b1;
		end
		if (policy_reg[POL_SX_EN_BIT] && (mgmt_ran_reg || policy_reg[POL_AG3_EN_BIT])) begin
			wired_on = 1'b1;
		end
		if (!ram_on && !mgmt_on && !(mgmt.mgmt_phy_keep && mgmt_ran_reg)) begin // Management keep wins
			if (state_reg == PWR_DEEP && policy_reg[POL_DSX_DIS_BIT]) begin
				wired_on = 1'b0;
			end
			if (on_battery && policy_reg[POL_DC_DIS_BIT]) begin
				wired_on = 1'b0;
			end
		end
		wireless_on = ram_on;
		if (ctrl_reg[CTL_WLAN_KEEP_BIT] && state_reg != PWR_DEEP) begin
			wireless_on = 1'b1;
		end
		if (mgmt.mgmt_wlan_access && (mgmt_on || (mgmt.mgmt_wlan_keep && state_reg != PWR_DEEP))) begin
			wireless_on = 1'b1;
		end
	end

	// All rail outputs registered from the same state so they move together
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sleep_ram_rail_off_n <= 1'b0;
			sleep_disk_rail_off_n <= 1'b0;
			soft_off_rail_off_n <= 1'b0;
			mgmt_rail_off_n <= 1'b0;
			wired_phy_rail_off_n <= 1'b0;
			wireless_phy_rail_off_n <= 1'b0;
		end else if (clk_en) begin
			sleep_ram_rail_off_n <= ram_on;
			// disk rail off in deeper states
			sleep_disk_rail_off_n <= state_reg < PWR_DISK;
			soft_off_rail_off_n <= state_reg < PWR_SOFT;
			mgmt_rail_off_n <= mgmt_on;
			wired_phy_rail_off_n <= wired_on;
			wireless_phy_rail_off_n <= wireless_on;
		end
	end

	// ----------------------------------------
	// Platform reset
	// ----------------------------------------
	// asynchronous on power-good loss
	always_ff @(posedge clk_sys or negedge core_power_good) begin
		if (!core_power_good) begin
			platform_reset_n <= 1'b0;
		end else if (!rst_n) begin
			platform_reset_n <= 1'b0;
		end else if (clk_en) begin
			platform_reset_n <= state_reg == PWR_WORK && reset_kind == RST_NONE;
		end
	end

	// ----------------------------------------
	// Shared pin
	// ----------------------------------------
	// Straight-to-off ack holds 0 briefly before handing over to policy
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_cnt_reg <= 8'h00;
		end else if (clk_en) begin
			if (reset_kind != RST_STRAIGHT) begin
				ack_cnt_reg <= 8'h00;
			end else if (ack_cnt_reg < 8'(ACK_ZERO_CYCLES)) begin
				ack_cnt_reg <= ack_cnt_reg + 8'h01;
			end
		end
	end

	always_comb begin
		pin_out_next = 1'b0;
		pin_oe_next = 1'b0;
		case (pin_mode)
			PIN_ACK: begin
				pin_oe_next = state_reg != PWR_DEEP;
				if (state_reg != PWR_WORK && !mgmt.mgmt_on_req) begin
					pin_out_next = mgmt.mgmt_ack_level;
				end
				if (reset_kind == RST_POWER_CYCLE || reset_kind == RST_GLOBAL) begin
					pin_oe_next = 1'b1;
					pin_out_next = 1'b0;
				end else if (reset_kind == RST_STRAIGHT) begin
					pin_oe_next = 1'b1;
					pin_out_next = ack_cnt_reg < 8'(ACK_ZERO_CYCLES) ? 1'b0 : mgmt.mgmt_ack_level;
				end
			end
			PIN_WARN: begin
				pin_out_next = state_reg != PWR_DEEP;
				pin_oe_next = state_reg != PWR_DEEP || suspend_well_reset_n;
			end
			PIN_GPIO: begin
				pin_out_next = ctrl_reg[CTL_DATA_BIT];
				pin_oe_next = ctrl_reg[CTL_DIR_BIT] && state_reg != PWR_DEEP;
			end
			default: begin
				pin_out_next = 1'b0;
				pin_oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shared_gp_pin_out <= 1'b0;
			shared_gp_pin_oe <= 1'b0;
		end else if (clk_en) begin
			shared_gp_pin_out <= pin_out_next;
			shared_gp_pin_oe <= pin_oe_next;
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// policy lives in the RTC well
	always_ff @(posedge clk_sys or negedge rtc_well_reset_n) begin
		if (!rtc_well_reset_n) begin
			policy_reg <= POLICY_RESET;
		end else if (clk_en && bus_req.wr && bus_req.addr == REG_POLICY) begin
			policy_reg <= bus_req.wdata & 32'h7800_0000;
		end
	end

	// Management run history also survives everything but the secondary RTC reset
	always_ff @(posedge clk_sys or negedge secondary_rtc_reset_n) begin
		if (!secondary_rtc_reset_n) begin
			mgmt_ran_reg <= 1'b0;
		end else if (clk_en && mgmt_rail_off_n) begin
			mgmt_ran_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
		end else if (clk_en && bus_req.wr && bus_req.addr == REG_CTRL) begin
			ctrl_reg <= bus_req.wdata & 32'h0000_01f8;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STS_STATE_LSB +: 3] = state_reg;
		status_word[STS_BATTERY_LOW_N_BIT] = batt_low;
		status_word[STS_DRAM_SHORT_BIT] = dram_short_reg;
		status_word[STS_MGMT_RAN_BIT] = mgmt_ran_reg;
		status_word[STS_PIN_BIT] = shared_gp_pin_in;
	end

	// Read data stands one cycle only; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data <= 32'h0000_0000;
		end else if (clk_en) begin
			rd_data <= 32'h0000_0000;
			if (bus_req.rd) begin
				case (bus_req.addr)
					REG_POLICY: rd_data <= policy_reg;
					REG_CTRL: rd_data <= ctrl_reg;
					REG_STATUS: rd_data <= status_word;
					default: rd_data <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_RAM_RAIL: assert property (clk_en |=> sleep_ram_rail_off_n == ($past(state_reg) == PWR_WORK))
		else $error("ram rail wrong for state");
	AST_SLEEP_RESET: assert property (clk_en && state_reg != PWR_WORK |=> !platform_reset_n)
		else $error("platform reset released in sleep");
	AST_DISK_DEEP: assert property (clk_en && state_reg >= PWR_DISK |=> !sleep_disk_rail_off_n)
		else $error("disk rail released in deep state");
	AST_STRETCH: assert property (clk_en && ctrl_reg[CTL_STRETCH_BIT] && state_reg >= PWR_DISK && !dram_met
		|=> state_reg >= PWR_DISK)
		else $error("dram woke before minimum off time");
	AST_PGOOD: assert property (!core_power_good && $past(!core_power_good) |-> !platform_reset_n)
		else $error("platform reset high without power good");
	AST_BATTERY_LOW_N_WAKE: assert property (clk_en && batt_low && state_reg != PWR_WORK
		|=> state_reg >= $past(state_reg))
		else $error("wake while battery low");
	AST_SMI: assert property (clk_en && bat_sync_reg && !bat_prev_reg && state_reg == PWR_WORK
		|=> battery_smi)
		else $error("no interrupt on battery low");
	AST_WIRED: assert property (sleep_ram_rail_off_n || mgmt_rail_off_n |-> wired_phy_rail_off_n)
		else $error("wired phy off while host or management on");
	AST_WIRELESS: assert property (sleep_ram_rail_off_n |-> wireless_phy_rail_off_n)
		else $error("wireless phy off while host on");
	AST_GPIO_DEEP: assert property (clk_en && state_reg == PWR_DEEP && pin_mode == PIN_GPIO
		|=> !shared_gp_pin_oe)
		else $error("gpio driven in deep sleep");
	AST_ACK_RESET: assert property (clk_en && pin_mode == PIN_ACK
		&& (reset_kind == RST_POWER_CYCLE || reset_kind == RST_GLOBAL)
		|=> shared_gp_pin_oe && !shared_gp_pin_out)
		else $error("ack not low during reset");
	AST_RTC_RESET: assert property (!rtc_well_reset_n |-> policy_reg == POLICY_RESET)
		else $error("policy kept through rtc reset");
	AST_SYNC: assert property (clk_en [*3] |-> batt_low == !$past(battery_low_n, 2))
		else $error("battery low sync depth wrong");

	COV_SLEEP_WAKE: cover property (state_reg == PWR_RAM ##[1:50] state_reg == PWR_WORK);
	COV_STRETCH_HOLD: cover property (!wake_ok && sleep_target == PWR_WORK && state_reg == PWR_DISK);
	COV_SMI: cover property (battery_smi);
	COV_DEEP_WARN: cover property (pin_mode == PIN_WARN && state_reg == PWR_DEEP && !shared_gp_pin_oe);
endmodule : src_sleep_rail_control

//--- test/src_board_model.sv
module src_board_model #(
	parameter int PG_DELAY = 10
) (
	input wire logic clk_sys,
	input wire logic sleep_ram_rail_off_n,
	input wire logic g3_req,
	input wire logic pg_fail,
	input wire logic shared_gp_pin_out,
	input wire logic shared_gp_pin_oe,
	output logic core_power_good,
	output logic rtc_well_reset_n,
	output logic secondary_rtc_reset_n,
	output logic shared_gp_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int rail_cnt = 0;
	logic pg_ok_reg = 1'b0;
	logic pin_last_reg = 1'b0;
	always @(posedge clk_sys) begin
		if (!sleep_ram_rail_off_n || g3_req) begin
			rail_cnt <= 0;
		end else if (rail_cnt < PG_DELAY) begin
			rail_cnt <= rail_cnt + 1;
		end
	end
	always @(posedge clk_sys) begin
		pg_ok_reg <= (rail_cnt >= PG_DELAY) && !g3_req;
	end
	// Failure drops good at once
	assign core_power_good = pg_ok_reg && !pg_fail;
	assign rtc_well_reset_n = !g3_req;
	assign secondary_rtc_reset_n = !g3_req;
	// No pull on the pin, so a floating pin toggles
	always @(posedge clk_sys) begin
		pin_last_reg <= shared_gp_pin_in;
	end
	assign shared_gp_pin_in = shared_gp_pin_oe ? shared_gp_pin_out : ~pin_last_reg;
endmodule : src_board_model

//--- test/tb_top.sv
module tb_top
	import src_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	src_bus_req_type bus_req = '0;
	logic [31:0] rd_data;
	src_pwr_type sleep_target = PWR_SOFT;
	src_mgmt_type mgmt = '0;
	src_rst_type reset_kind = RST_NONE;
	logic on_battery = 1'b0;
	logic battery_low_n = 1'b1;
	logic suspend_well_reset_n = 1'b1;
	logic clk_en = 1'b1;
	// Starts low so the first edge of the board reset is a clean fall
	logic g3_req = 1'b0;
	logic pg_fail = 1'b0;
	logic core_power_good, rtc_well_reset_n, secondary_rtc_reset_n, pin_in;
	logic ram_n, disk_n, soft_n, mgmt_n, wired_n, wless_n, prst_n, smi, pin_out, pin_oe;
	logic [31:0] rv;
	int error_cnt = 0;
	int checks = 0;
	// Free running system clock
	always #5 clk_sys = ~clk_sys;
	// Short DRAM minimum keeps the run brief
	src_sleep_rail_control #(.DRAM_MIN_CYCLES(20)) u_src_sleep_rail_control (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.sleep_target(sleep_target),
		.mgmt(mgmt),
		.reset_kind(reset_kind),
		.on_battery(on_battery),
		.core_power_good(core_power_good),
		.battery_low_n(battery_low_n),
		.suspend_well_reset_n(suspend_well_reset_n),
		.rtc_well_reset_n(rtc_well_reset_n),
		.secondary_rtc_reset_n(secondary_rtc_reset_n),
		.shared_gp_pin_in(pin_in),
		.sleep_ram_rail_off_n(ram_n),
		.sleep_disk_rail_off_n(disk_n),
		.soft_off_rail_off_n(soft_n),
		.mgmt_rail_off_n(mgmt_n),
		.wired_phy_rail_off_n(wired_n),
		.wireless_phy_rail_off_n(wless_n),
		.platform_reset_n(prst_n),
		.battery_smi(smi),
		.shared_gp_pin_out(pin_out),
		.shared_gp_pin_oe(pin_oe)
	);
	src_board_model u_src_board_model (
		.clk_sys(clk_sys),
		.sleep_ram_rail_off_n(ram_n),
		.g3_req(g3_req),
		.pg_fail(pg_fail),
		.shared_gp_pin_out(pin_out),
		.shared_gp_pin_oe(pin_oe),
		.core_power_good(core_power_good),
		.rtc_well_reset_n(rtc_well_reset_n),
		.secondary_rtc_reset_n(secondary_rtc_reset_n),
		.shared_gp_pin_in(pin_in)
	);
	// ----------------------------------------
	// Bus, compare and wait helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic chk_bit(input string name, input logic exp, input logic got);
		chk(name, {31'h0, exp}, {31'h0, got});
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_sys);
		bus_req <= '0;
		@(negedge clk_sys);
		rv = rd_data;
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : wait_n
	// Rails follow two edges after the request
	task automatic go(input src_pwr_type s);
		@(posedge clk_sys);
		sleep_target <= s;
		wait_n(3);
	endtask : go
	task automatic give_verdict();
		$display("TB: checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(REG_POLICY);
		chk("policy reset", POLICY_RESET, rv);
		rd(REG_CTRL);
		chk("ctrl reset", CTRL_RESET, rv);
		wr(REG_POLICY, 32'hffff_ffff);
		rd(REG_POLICY);
		chk("policy bits", 32'h7800_0000, rv);
		rd(8'h0c);
		chk("unmapped read", 32'h0, rv);
	endtask : t_regs
	task automatic t_sleep();
		src_pwr_type sl[4] = '{PWR_RAM, PWR_DISK, PWR_SOFT, PWR_DEEP};
		go(PWR_WORK);
		wait_n(15);
		chk_bit("ram rail", 1'b1, ram_n);
		chk_bit("wired rail", 1'b1, wired_n);
		chk_bit("wireless rail", 1'b1, wless_n);
		chk_bit("reset up", 1'b1, prst_n);
		@(posedge clk_sys);
		pg_fail <= 1'b1;
		#2;
		chk_bit("reset async", 1'b0, prst_n);
		@(posedge clk_sys);
		pg_fail <= 1'b0;
		foreach (sl[i]) begin
			go(sl[i]);
			chk_bit("ram rail", 1'b0, ram_n);
			chk_bit("disk rail", sl[i] == PWR_RAM, disk_n);
			chk_bit("reset in sleep", 1'b0, prst_n);
		end
	endtask : t_sleep
	task automatic t_battery();
		int n;
		go(PWR_WORK);
		@(posedge clk_sys);
		battery_low_n <= 1'b0;
		n = 0;
		repeat (3) begin
			@(negedge clk_sys);
			chk_bit("smi early", 1'b0, smi);
		end
		repeat (6) begin
			@(negedge clk_sys);
			n += int'(smi === 1'b1);
		end
		chk("smi pulses", 32'd1, n);
		go(PWR_RAM);
		go(PWR_WORK);
		wait_n(6);
		chk_bit("wake blocked", 1'b0, ram_n);
		@(posedge clk_sys);
		battery_low_n <= 1'b1;
		wait_n(8);
		chk_bit("wake after", 1'b1, ram_n);
		// Enable low must freeze the state despite a sleep request
		@(posedge clk_sys);
		clk_en <= 1'b0;
		sleep_target <= PWR_RAM;
		wait_n(4);
		chk_bit("frozen rail", 1'b1, ram_n);
		@(posedge clk_sys);
		sleep_target <= PWR_WORK;
		clk_en <= 1'b1;
	endtask : t_battery
	task automatic t_stretch();
		wr(REG_CTRL, 32'h8);
		go(PWR_DISK);
		go(PWR_WORK);
		wait_n(2);
		chk_bit("dram held off", 1'b0, disk_n);
		wait_n(30);
		chk_bit("dram back", 1'b1, disk_n);
		wr(REG_CTRL, 32'h0);
		wr(REG_STATUS, 32'h10);
		rd(REG_STATUS);
		chk_bit("short cleared", 1'b0, rv[STS_DRAM_SHORT_BIT]);
		go(PWR_DISK);
		go(PWR_WORK);
		rd(REG_STATUS);
		chk_bit("short seen", 1'b1, rv[STS_DRAM_SHORT_BIT]);
	endtask : t_stretch
	task automatic t_phy();
		logic [31:0] pol[5] = '{32'h5800_0000, 32'h0, 32'h3800_0000, 32'h1800_0000, 32'h5800_0000};
		logic bat[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		src_pwr_type st[5] = '{PWR_SOFT, PWR_SOFT, PWR_DEEP, PWR_DEEP, PWR_SOFT};
		logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		foreach (pol[i]) begin
			wr(REG_POLICY, pol[i]);
			on_battery <= bat[i];
			go(st[i]);
			chk_bit("wired policy", ex[i], wired_n);
		end
		// Management keep must beat the battery drop
		@(posedge clk_sys);
		mgmt <= '{mgmt_phy_keep: 1'b1, default: 1'b0};
		wait_n(2);
		chk_bit("wired mgmt keep", 1'b1, wired_n);
		@(posedge clk_sys);
		on_battery <= 1'b0;
		mgmt <= '0;
		wr(REG_CTRL, 32'h10);
		wait_n(2);
		chk_bit("wireless keep", 1'b1, wless_n);
		wr(REG_CTRL, 32'h0);
		wait_n(2);
		chk_bit("wireless drop", 1'b0, wless_n);
		@(posedge clk_sys);
		mgmt <= '{mgmt_on_req: 1'b1, mgmt_wlan_access: 1'b1, default: 1'b0};
		wait_n(4);
		chk_bit("wireless mgmt", 1'b1, wless_n);
		chk_bit("wired mgmt", 1'b1, wired_n);
		@(posedge clk_sys);
		mgmt <= '0;
	endtask : t_phy
	task automatic t_pin();
		logic [31:0] cv[6] = '{32'h0, 32'h20, 32'h40, 32'h1c0, 32'h0c0, 32'h60};
		logic eoe[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		logic eout[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		go(PWR_WORK);
		foreach (cv[i]) begin
			wr(REG_CTRL, cv[i]);
			rd(REG_STATUS);
			chk_bit("pin drive", eoe[i], pin_oe);
			if (eoe[i]) begin
				chk_bit("pin level", eout[i], rv[STS_PIN_BIT]);
			end
		end
		wr(REG_CTRL, 32'h1c0);
		go(PWR_DEEP);
		chk_bit("gpio deep", 1'b0, pin_oe);
		wr(REG_CTRL, 32'h0);
		wait_n(2);
		chk_bit("ack deep", 1'b0, pin_oe);
		wr(REG_CTRL, 32'h20);
		wait_n(2);
		chk_bit("warn deep", 1'b0, pin_out);
		@(posedge clk_sys);
		suspend_well_reset_n <= 1'b0;
		wait_n(2);
		chk_bit("warn float", 1'b0, pin_oe);
		@(posedge clk_sys);
		suspend_well_reset_n <= 1'b1;
	endtask : t_pin
	task automatic t_reset_pin();
		wr(REG_CTRL, 32'h0);
		go(PWR_WORK);
		@(posedge clk_sys);
		mgmt <= '{mgmt_ack_level: 1'b1, default: 1'b0};
		for (int k = 1; k < 4; k++) begin
			@(posedge clk_sys);
			reset_kind <= src_rst_type'(k);
			wait_n(2);
			chk_bit("reset held", 1'b0, prst_n);
			chk_bit("ack zero", 1'b0, pin_out);
			chk_bit("ack driven", 1'b1, pin_oe);
		end
		wait_n(20);
		chk_bit("ack policy", 1'b1, pin_out);
		@(posedge clk_sys);
		reset_kind <= RST_NONE;
		mgmt <= '0;
	endtask : t_reset_pin
	task automatic t_rtc();
		go(PWR_SOFT);
		wr(REG_POLICY, 32'h7800_0000);
		g3_req <= 1'b1;
		wait_n(3);
		@(posedge clk_sys);
		g3_req <= 1'b0;
		rd(REG_POLICY);
		chk("policy cleared", 32'h0, rv);
		rd(REG_STATUS);
		chk_bit("mgmt ran cleared", 1'b0, rv[STS_MGMT_RAN_BIT]);
	endtask : t_rtc
	// Main sequence
	initial begin
		@(posedge clk_sys);
		g3_req <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		g3_req <= 1'b0;
		t_regs();
		t_sleep();
		t_battery();
		t_stretch();
		t_phy();
		t_pin();
		t_reset_pin();
		t_rtc();
		give_verdict();
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		give_verdict();
	end
endmodule : tb_top
